// File: design/pmuseq_pkg.sv
package pmuseq_pkg;

  // Channel order in the per-channel vectors; ramp vectors omit boost and hold channel i at index i-1
  localparam int NCH = 7;
  localparam int CH_BOOST = 0;
  localparam int CH_MAIN = 1;
  localparam int CH_BUCK = 2;
  localparam int CH_AUX_CTRL_ONE = 3;
  localparam int CH_AUX_CTRL_FOUR = 6;
  localparam int NRAMP = 6;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_ONESHOT_NS = 200;
  localparam int OSC_ONESHOT_CYC =
    (OSC_ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ONESHOT_W = 5;
  localparam int RAMP_W = 13;
  localparam logic [12:0] RAMP_FULL = 13'h1000;
  localparam logic [12:0] SS_STEP_NORM = 13'h0001;
  localparam logic [12:0] SS_STEP_BUCK = 13'h0002;
  localparam logic [12:0] BOOST_SS_CYC = 13'h1000;
  localparam logic [10:0] AUX_DELAY_CYC = 11'h400;
  localparam int FAULT_CYC_DEFAULT = 100000;
  localparam int FAULT_W = 17;

  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [6:0] CTRL_RESET = 7'h7f;
  localparam int ST_BOOST_LSB = 0;
  localparam int ST_LATCHED = 4;
  localparam int ST_REF_EN = 5;
  localparam int ST_CHAN_ON_LSB = 6;
  localparam int ST_SS_DONE_LSB = 13;
  localparam int ST_PINS_LSB = 20;
  localparam int FLT_UV = 7;

  typedef enum logic [3:0] {
    PMUSEQ_B_OFF = 4'h1,
    PMUSEQ_B_START = 4'h2,
    PMUSEQ_B_PWM = 4'h4,
    PMUSEQ_B_RUN = 4'h8
  } pmuseq_boost_t;

  typedef struct packed {
    logic aux_enable_four;
    logic aux_enable_three;
    logic aux_enable_two;
    logic aux_enable_one;
    logic buck_enable_in;
    logic main_enable_in;
    logic boost_enable_in;
  } pmuseq_en_t;

  typedef struct packed {
    logic buck_good_n;
    logic aux_one_good_n;
    logic aux_four_good_n;
    logic fault_flag_out;
  } pmuseq_pins_t;

  typedef logic [NRAMP-1:0][RAMP_W-1:0] pmuseq_ramp_t;

  typedef struct packed {
    pmuseq_boost_t bst;
    logic [12:0] bst_tmr;
    logic [10:0] aux_dly;
    pmuseq_ramp_t ramp;
    logic [NCH-1:0][FAULT_W-1:0] fcnt;
    logic latched;
    logic [NCH-1:0] cause;
    logic uv_evt;
    logic [NCH-1:0] allow;
    logic [NCH-1:0] chan_on;
    pmuseq_pins_t pin_oe;
    logic ref_en;
    logic trip_prev;
    logic [ONESHOT_W-1:0] os_cnt;
    logic discharge;
    logic ack;
    logic [31:0] dat;
  } pmuseq_state_t;

endpackage

// File: design/pmuseq_top.sv
// The register addresses and the Wishbone interface to the registers were left to the implementer.
module pmuseq_top #(
  parameter int FAULT_CYCLES = pmuseq_pkg::FAULT_CYC_DEFAULT
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire pmuseq_pkg::pmuseq_en_t ch_en_i,
  input wire logic [6:0] in_reg_i,
  input wire logic boost_rail_ok_i,
  input wire logic thermal_limit_i,
  input wire logic osc_trip_i,
  input wire pmuseq_pkg::pmuseq_pins_t stat_in_i,
  output pmuseq_pkg::pmuseq_pins_t stat_out_o,
  output pmuseq_pkg::pmuseq_pins_t stat_oe_o,
  output logic [6:0] chan_on_o,
  output pmuseq_pkg::pmuseq_ramp_t ramp_ref_o,
  output logic ref_enable_o,
  output logic osc_discharge_o,
  output logic boost_startup_osc_o,
  output logic boost_pwm_o
);

  localparam logic [16:0] FAULT_LIM = 17'(FAULT_CYCLES);

  pmuseq_pkg::pmuseq_state_t state_reg;
  pmuseq_pkg::pmuseq_state_t state_next;

  logic [6:0] en_vec;
  logic osc_tick;
  logic boost_run;
  logic aux_ready;
  logic bus_req;
  logic [6:0] act;
  logic [6:0] ss_done;
  logic [6:0] watch;

  assign en_vec = ch_en_i;
  // Trip accepted only outside the discharge window
  assign osc_tick = osc_trip_i & ~state_reg.trip_prev &
                    (state_reg.os_cnt == '0);
  assign boost_run = (state_reg.bst == pmuseq_pkg::PMUSEQ_B_RUN);
  assign aux_ready = (state_reg.aux_dly == pmuseq_pkg::AUX_DELAY_CYC);
  assign bus_req = wb_cyc_i & wb_stb_i;

  // Boost itself has no ramp: done once regulated
  assign act[pmuseq_pkg::CH_BOOST] =
    (state_reg.bst != pmuseq_pkg::PMUSEQ_B_OFF);
  assign ss_done[pmuseq_pkg::CH_BOOST] = boost_run;
  assign watch[pmuseq_pkg::CH_BOOST] =
    boost_run & ~in_reg_i[pmuseq_pkg::CH_BOOST];

  genvar gi;
  generate
    for (gi = 1; gi < pmuseq_pkg::NCH; gi++) begin : g_ch
      if (gi >= pmuseq_pkg::CH_AUX_CTRL_ONE) begin : g_aux
        assign act[gi] = en_vec[gi] & state_reg.allow[gi] & boost_run &
                         ~state_reg.latched & ~thermal_limit_i &
                         aux_ready;
      end else begin : g_core
        assign act[gi] = en_vec[gi] & state_reg.allow[gi] & boost_run &
                         ~state_reg.latched &
                         ~thermal_limit_i;
      end
      assign ss_done[gi] = (state_reg.ramp[gi-1] == pmuseq_pkg::RAMP_FULL);
      // No fault watch until the ramp has finished
      assign watch[gi] = act[gi] & ss_done[gi] & ~in_reg_i[gi];
    end
  endgenerate

  always_comb begin
    state_next = state_reg;

    // Oscillator one-shot
    state_next.trip_prev = osc_trip_i;
    if (osc_tick) begin
      state_next.os_cnt = pmuseq_pkg::ONESHOT_W'(
        pmuseq_pkg::OSC_ONESHOT_CYC);
    end else if (state_reg.os_cnt != '0) begin
      state_next.os_cnt = state_reg.os_cnt - 5'h01;
    end
    state_next.discharge = (state_next.os_cnt != '0);

    // Bus slave: answer one cycle after request, act on the ack edge
    state_next.ack = bus_req & ~state_reg.ack;
    state_next.dat = 32'h0000_0000;
    if (bus_req & ~state_reg.ack & ~wb_we_i) begin
      case (wb_adr_i)
        pmuseq_pkg::ADDR_CTRL: begin
          state_next.dat[6:0] = state_reg.allow;
        end
        pmuseq_pkg::ADDR_STATUS: begin
          state_next.dat[pmuseq_pkg::ST_BOOST_LSB +: 4] = state_reg.bst;
          state_next.dat[pmuseq_pkg::ST_LATCHED] = state_reg.latched;
          state_next.dat[pmuseq_pkg::ST_REF_EN] = state_reg.ref_en;
          state_next.dat[pmuseq_pkg::ST_CHAN_ON_LSB +: 7] =
            state_reg.chan_on;
          state_next.dat[pmuseq_pkg::ST_SS_DONE_LSB +: 7] = ss_done;
          state_next.dat[pmuseq_pkg::ST_PINS_LSB +: 4] = stat_in_i;
        end
        pmuseq_pkg::ADDR_FAULT: begin
          state_next.dat[6:0] = state_reg.cause;
          state_next.dat[pmuseq_pkg::FLT_UV] = state_reg.uv_evt;
        end
        default: begin
          state_next.dat = 32'h0000_0000;
        end
      endcase
    end
    if (bus_req & state_reg.ack & wb_we_i & wb_sel_i[0]) begin
      case (wb_adr_i)
        pmuseq_pkg::ADDR_CTRL: begin
          state_next.allow = wb_dat_i[6:0];
        end
        pmuseq_pkg::ADDR_FAULT: begin
          state_next.cause = state_reg.cause & ~wb_dat_i[6:0];
          state_next.uv_evt = state_reg.uv_evt &
                              ~wb_dat_i[pmuseq_pkg::FLT_UV];
        end
        default: begin
          state_next.allow = state_next.allow;
        end
      endcase
    end

    // Boost sequencer
    case (state_reg.bst)
      pmuseq_pkg::PMUSEQ_B_OFF: begin
        state_next.bst_tmr = '0;
        state_next.bst = pmuseq_pkg::PMUSEQ_B_START;
      end
      pmuseq_pkg::PMUSEQ_B_START: begin
        state_next.bst_tmr = '0;
        if (boost_rail_ok_i) begin
          state_next.bst = pmuseq_pkg::PMUSEQ_B_PWM;
        end
      end
      pmuseq_pkg::PMUSEQ_B_PWM: begin
        if (!boost_rail_ok_i) begin
          state_next.bst = pmuseq_pkg::PMUSEQ_B_START;
          state_next.uv_evt = 1'b1;
        end else if (in_reg_i[pmuseq_pkg::CH_BOOST]) begin
          state_next.bst = pmuseq_pkg::PMUSEQ_B_RUN;
        end else if (osc_tick) begin
          if (state_reg.bst_tmr == pmuseq_pkg::BOOST_SS_CYC - 13'h0001)
          begin
            // Interval over without regulation: fault and retry
            state_next.bst = pmuseq_pkg::PMUSEQ_B_START;
            state_next.uv_evt = 1'b1;
          end else begin
            state_next.bst_tmr = state_reg.bst_tmr + 13'h0001;
          end
        end
      end
      pmuseq_pkg::PMUSEQ_B_RUN: begin
        if (!boost_rail_ok_i) begin
          // Immediate shutdown of the regulated channels, boost back to start, no timer
          state_next.bst = pmuseq_pkg::PMUSEQ_B_START;
          state_next.uv_evt = 1'b1;
        end
      end
      default: begin
        state_next.bst = pmuseq_pkg::PMUSEQ_B_OFF;
      end
    endcase
    if (!en_vec[pmuseq_pkg::CH_BOOST] | state_reg.latched |
        thermal_limit_i) begin
      state_next.bst = pmuseq_pkg::PMUSEQ_B_OFF;
      state_next.bst_tmr = '0;
    end

    // Aux start delay after boost regulation
    if (!boost_run) begin
      state_next.aux_dly = '0;
    end else if (osc_tick & ~aux_ready) begin
      state_next.aux_dly = state_reg.aux_dly + 11'h001;
    end

    // Soft-start ramps of the regulated channels
    for (int i = 1; i < pmuseq_pkg::NCH; i++) begin
      if (!act[i]) begin
        state_next.ramp[i-1] = '0;
      end else if (osc_tick & ~ss_done[i]) begin
        if (i == pmuseq_pkg::CH_BUCK) begin
          state_next.ramp[i-1] = state_reg.ramp[i-1] +
                                 pmuseq_pkg::SS_STEP_BUCK;
        end else begin
          state_next.ramp[i-1] = state_reg.ramp[i-1] +
                                 pmuseq_pkg::SS_STEP_NORM;
        end
      end
    end

    // Fault timers and global latch-off
    if (!en_vec[pmuseq_pkg::CH_BOOST]) begin
      state_next.latched = 1'b0;
    end
    for (int i = 0; i < pmuseq_pkg::NCH; i++) begin
      if (!watch[i]) begin
        state_next.fcnt[i] = '0;
      end else if (osc_tick) begin
        if (state_reg.fcnt[i] == FAULT_LIM - 17'h0_0001) begin
          state_next.latched = 1'b1;
          state_next.cause[i] = 1'b1;
          state_next.fcnt[i] = '0;
        end else begin
          state_next.fcnt[i] = state_reg.fcnt[i] + 17'h0_0001;
        end
      end
    end

    // Registered outputs
    state_next.chan_on = act;
    state_next.ref_en = en_vec[pmuseq_pkg::CH_BOOST] &
                        boost_rail_ok_i;
    state_next.pin_oe.buck_good_n = act[pmuseq_pkg::CH_BUCK] &
      ss_done[pmuseq_pkg::CH_BUCK] & ~state_reg.latched &
      ~thermal_limit_i;
    state_next.pin_oe.aux_one_good_n = act[pmuseq_pkg::CH_AUX_CTRL_ONE] &
      ss_done[pmuseq_pkg::CH_AUX_CTRL_ONE] & ~state_reg.latched &
      ~thermal_limit_i;
    state_next.pin_oe.aux_four_good_n = act[pmuseq_pkg::CH_AUX_CTRL_FOUR] &
      ss_done[pmuseq_pkg::CH_AUX_CTRL_FOUR] & in_reg_i[pmuseq_pkg::CH_AUX_CTRL_FOUR];
    state_next.pin_oe.fault_flag_out = boost_run &
      ~state_reg.latched;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg.bst <= pmuseq_pkg::PMUSEQ_B_OFF;
      state_reg.bst_tmr <= '0;
      state_reg.aux_dly <= '0;
      state_reg.ramp <= '0;
      state_reg.fcnt <= '0;
      state_reg.latched <= 1'b0;
      state_reg.cause <= '0;
      state_reg.uv_evt <= 1'b0;
      state_reg.allow <= pmuseq_pkg::CTRL_RESET;
      state_reg.chan_on <= '0;
      state_reg.pin_oe <= '0;
      state_reg.ref_en <= 1'b0;
      state_reg.trip_prev <= 1'b0;
      state_reg.os_cnt <= '0;
      state_reg.discharge <= 1'b0;
      state_reg.ack <= 1'b0;
      state_reg.dat <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pins only ever sink; level comes from the enable
  assign stat_out_o = '0;
  assign stat_oe_o = state_reg.pin_oe;
  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.dat;
  assign chan_on_o = state_reg.chan_on;
  assign ramp_ref_o = state_reg.ramp;
  assign ref_enable_o = state_reg.ref_en;
  assign osc_discharge_o = state_reg.discharge;
  assign boost_startup_osc_o =
    (state_reg.bst == pmuseq_pkg::PMUSEQ_B_START);
  assign boost_pwm_o = (state_reg.bst == pmuseq_pkg::PMUSEQ_B_PWM) |
                       boost_run;

endmodule

// File: verification/pmuseq_props.sv
module pmuseq_props #(
  parameter int FAULT_CYCLES = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pmuseq_pkg::pmuseq_en_t ch_en_i,
  input wire logic boost_rail_ok_i,
  input wire logic thermal_limit_i,
  input wire logic osc_trip_i,
  input wire pmuseq_pkg::pmuseq_pins_t stat_out_o,
  input wire pmuseq_pkg::pmuseq_pins_t stat_oe_o,
  input wire logic [6:0] chan_on_o,
  input wire pmuseq_pkg::pmuseq_ramp_t ramp_ref_o,
  input wire logic ref_enable_o,
  input wire logic osc_discharge_o,
  input wire logic boost_pwm_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  logic [4:0] dis_reg;
  logic [4:0] dis_next;
  logic others_on;
  assign others_on = |chan_on_o[6:1];
  always_comb begin
    dis_next = osc_discharge_o ? dis_reg + 5'h1 : 5'h0;
  end
  always_ff @(posedge mclk_i) begin
    dis_reg <= rst_i ? 5'h0 : dis_next;
  end
  sink_only_a: assert property (stat_out_o == 4'h0)
    else $error("status pin driven high");
  discharge_len_a: assert property (
    $fell(osc_discharge_o) |-> dis_reg == 5'h14)
    else $error("discharge pulse length wrong");
  discharge_start_a: assert property (
    $rose(osc_trip_i) && !osc_discharge_o |=> osc_discharge_o)
    else $error("trip did not start discharge");
  ref_gate_a: assert property (
    ref_enable_o |->
    $past(ch_en_i.boost_enable_in) && $past(boost_rail_ok_i))
    else $error("reference on without enable and rail");
  uv_off_a: assert property (
    !boost_rail_ok_i |=> ##1 chan_on_o[6:1] == 6'h00)
    else $error("channels on during undervoltage");
  wait_boost_a: assert property (
    $rose(others_on) |-> $past(boost_pwm_o))
    else $error("channel started before boost");
  pwm_rail_a: assert property (
    $rose(boost_pwm_o) |-> $past(boost_rail_ok_i))
    else $error("pwm entered below rail level");
  flag_run_a: assert property (
    stat_oe_o.fault_flag_out |-> $past(boost_pwm_o))
    else $error("fault flag sinks outside run");
  thermal_float_a: assert property (
    thermal_limit_i ##1 thermal_limit_i |=>
    !stat_oe_o.buck_good_n && !stat_oe_o.aux_one_good_n)
    else $error("good pin sinks in thermal limit");
  en_stop_a: assert property (
    !ch_en_i.buck_enable_in ##1 !ch_en_i.buck_enable_in |=>
    ramp_ref_o[1] == 13'h0 && !chan_on_o[2])
    else $error("disabled channel still ramping");
  cover property ($rose(boost_pwm_o));
  cover property ($rose(stat_oe_o.buck_good_n));
  cover property ($fell(stat_oe_o.fault_flag_out));
endmodule

bind pmuseq_top pmuseq_props #(.FAULT_CYCLES(FAULT_CYCLES)) u_props (
  .mclk_i(mclk_i), .rst_i(rst_i), .ch_en_i(ch_en_i),
  .boost_rail_ok_i(boost_rail_ok_i), .thermal_limit_i(thermal_limit_i),
  .osc_trip_i(osc_trip_i), .stat_out_o(stat_out_o), .stat_oe_o(stat_oe_o),
  .chan_on_o(chan_on_o), .ramp_ref_o(ramp_ref_o),
  .ref_enable_o(ref_enable_o), .osc_discharge_o(osc_discharge_o),
  .boost_pwm_o(boost_pwm_o)
);

// File: verification/pmuseq_loads.sv
module pmuseq_loads (
  input wire logic mclk_i,
  input wire logic run_i,
  input wire pmuseq_pkg::pmuseq_pins_t oe_i,
  output pmuseq_pkg::pmuseq_pins_t pin_o,
  output logic trip_o,
  output int ticks_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] gap = 5'h0;
  // Pull-ups on all status lines, drain pulls low
  assign pin_o = ~oe_i;
  initial begin
    trip_o = 1'b0;
    ticks_o = 0;
  end
  // Comparator trips once every 22 clocks, clear of discharge
  always @(posedge mclk_i) begin
    gap <= (gap == 5'h15) ? 5'h0 : gap + 5'h1;
    trip_o <= run_i && gap == 5'h15;
    if (run_i && gap == 5'h15) begin
      ticks_o <= ticks_o + 1;
    end
  end
endmodule

// File: verification/pmuseq_top_tb.sv
module pmuseq_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, bso, bpwm, refen, dis;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0, rdat;
  pmuseq_pkg::pmuseq_en_t en = '0;
  logic [6:0] inreg = 7'h0, chon;
  logic rail = 1'b0, therm = 1'b0, run = 1'b1, trip;
  pmuseq_pkg::pmuseq_pins_t pins, sout, soe;
  pmuseq_pkg::pmuseq_ramp_t ramp;
  int ticks, fails = 0, n_tests = 0;
  always #5 mclk_i = ~mclk_i;
  pmuseq_top #(.FAULT_CYCLES(8)) u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ch_en_i(en), .in_reg_i(inreg),
    .boost_rail_ok_i(rail), .thermal_limit_i(therm), .osc_trip_i(trip),
    .stat_in_i(pins), .stat_out_o(sout), .stat_oe_o(soe), .chan_on_o(chon),
    .ramp_ref_o(ramp), .ref_enable_o(refen), .osc_discharge_o(dis),
    .boost_startup_osc_o(bso), .boost_pwm_o(bpwm));
  pmuseq_loads u_loads (.mclk_i(mclk_i), .run_i(run), .oe_i(soe),
    .pin_o(pins), .trip_o(trip), .ticks_o(ticks));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #800_000;
    fails++;
    give_verdict();
  end
  initial begin
    logic [31:0] q;
    int t0;
    int n;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0, q); chk(q, 32'h0000_007f);
    wb(1'b0, 8'h04, 32'h0, q); chk(q, 32'h00f0_0001);
    wb(1'b0, 8'h10, 32'h0, q); chk(q, 32'h0);
    $display("reset test done");
    @(posedge mclk_i);
    en.boost_enable_in <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk(bso, 1'b1);
    rail <= 1'b1;
    run <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk(bpwm, 1'b1);
    chk(refen, 1'b1);
    inreg <= 7'h7f;
    repeat (3) @(posedge mclk_i);
    chk(pins.fault_flag_out, 1'b0);
    run <= 1'b0;
    repeat (25) @(posedge mclk_i);
    en.main_enable_in <= 1'b1;
    en.buck_enable_in <= 1'b1;
    en.aux_enable_one <= 1'b1;
    en.aux_enable_four <= 1'b1;
    @(posedge mclk_i);
    t0 = ticks;
    run <= 1'b1;
    n = 0;
    while (ramp[1] !== 13'h1000 && n < 60000) begin
      @(posedge mclk_i);
      n++;
    end
    chk(ticks - t0, 32'h0000_0800);
    chk(ramp[0], 13'h0800);
    chk(ramp[2], 13'h0400);
    chk(ramp[5], 13'h0400);
    chk(pins.aux_one_good_n, 1'b1);
    chk(pins.aux_four_good_n, 1'b1);
    repeat (3) @(posedge mclk_i);
    chk(pins.buck_good_n, 1'b0);
    $display("startup test done");
    inreg[2] <= 1'b0;
    repeat (110) @(posedge mclk_i);
    inreg[2] <= 1'b1;
    @(posedge mclk_i);
    inreg[2] <= 1'b0;
    repeat (110) @(posedge mclk_i);
    chk(pins.fault_flag_out, 1'b0);
    repeat (132) @(posedge mclk_i);
    chk(pins.fault_flag_out, 1'b1);
    chk(pins.buck_good_n, 1'b1);
    chk(chon, 7'h00);
    wb(1'b0, 8'h08, 32'h0, q); chk(q, 32'h0000_0004);
    wb(1'b1, 8'h08, 32'h0000_0004, q);
    wb(1'b0, 8'h08, 32'h0, q); chk(q, 32'h0);
    repeat (100) @(posedge mclk_i);
    chk(chon, 7'h00);
    en.boost_enable_in <= 1'b0;
    inreg[2] <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk(refen, 1'b0);
    wb(1'b0, 8'h04, 32'h0, q); chk(q[4], 1'b0);
    $display("latch test done");
    en.boost_enable_in <= 1'b1;
    repeat (10) @(posedge mclk_i);
    chk(chon[2], 1'b1);
    repeat (50) @(posedge mclk_i);
    chk(ramp[1] == 13'h0000, 1'b0);
    en.buck_enable_in <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk(ramp[1], 13'h0000);
    chk(chon[2], 1'b0);
    en.buck_enable_in <= 1'b1;
    rail <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk(chon[6:1], 6'h00);
    chk(bso, 1'b1);
    chk(refen, 1'b0);
    $display("undervoltage test done");
    rail <= 1'b1;
    therm <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk(pins.buck_good_n, 1'b1);
    therm <= 1'b0;
    $display("thermal test done");
    give_verdict();
  end
endmodule
